// *** design/oob_signal_transmitter.sv ***
// Purpose: Builds wake, init/reset and identify OOB signals for the phy
// Assumes: Requests and status come from logic on the core clock
// Notes: Period timing is accurate to one clock cycle, with no drift
// What this block does
// - Every period is timed in OOB units of about 666.67 ps.
// - The unit stays the generation-1 unit interval whatever burst rate.
// - Every burst period lasts 160 units for all signals.
// - Idle lasts 160, 480 or 1440 units; idle length tells signals apart.
// - Negation idle lasts 280, 800 or 2400 units after the last burst.
// - Six idle-then-burst pairs are sent, then the negation period.
// - Bursts carry back-to-back ALIGN primitives; idle periods carry D.C. idle.
// - Line transitions appear only during burst periods.
// - Bursts are preferably sent at generation-1 rate.
// - At generation-2 rate a burst holds twice the ALIGN primitives.
// - A phy supporting SATA always bursts at generation-1 rate.
// - Otherwise generation 1 if able, else lowest rate, never faster.
// - After identify, wait at least 13.65 us for the partner's reply.
// - Each completed signal sends its sent message to the reset machine.
// - Init and host reset are one signal with identical timing.
`timescale 1ns/1ps
`include "oob_consts.svh"

module oob_signal_transmitter #(
  parameter int unsigned REPEATS = `OOB_REPEATS,
  parameter int unsigned TIMEOUT_CYCLES = `OOB_IDENT_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Signal request
  input wire logic i_req_valid,
  input wire oob_pkg::oob_sig_t i_req_kind,
  // Phy capabilities
  input wire logic i_sata_supported,
  input wire logic i_gen1_capable,
  input wire oob_pkg::link_rate_t i_lowest_rate,
  // Partner identify seen
  input wire logic i_identify_detected,
  // Line control
  output logic o_tx_burst,
  output logic o_tx_dc_idle,
  output oob_pkg::link_rate_t o_burst_rate,
  output logic [3:0] o_burst_dwords,
  // Status and messages
  output logic o_tx_ready,
  output logic o_wake_sent_msg,
  output logic o_init_sent_msg,
  output logic o_identify_sent_msg,
  output logic o_identify_timeout
);

  localparam int unsigned LEN_W = 12;
  localparam int unsigned CNT_W = 12;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (REPEATS < 1 || REPEATS > 7) begin : g_bad_repeats
    $error("REPEATS out of range");
  end
  if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 4095) begin : g_bad_timeout
    $error("TIMEOUT_CYCLES out of range");
  end
  if (`OOB_CLK_PERIOD_PS * 3 != `OOB_CLK_THIRDS_NS * 1000) begin : g_bad_clk
    $error("Clock period not a whole number of thirds of a ns");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  oob_pkg::tx_state_t state_q;
  oob_pkg::tx_state_t state_d;
  oob_pkg::oob_sig_t kind_q;
  logic [2:0] rep_q;
  logic [2:0] rep_d;
  logic wait_q;
  logic wait_d;
  logic [CNT_W-1:0] wait_cnt_q;
  logic timer_done;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire logic accept = i_req_valid && (state_q == oob_pkg::ST_IDLE);
  wire logic last_rep = rep_q == 3'(REPEATS - 1);
  wire logic sig_end = (state_q == oob_pkg::ST_NEGATE) && timer_done;
  wire logic [LEN_W-1:0] idle_len = (kind_q == oob_pkg::SIG_WAKE) ? LEN_W'(`OOB_WAKE_IDLE_UNITS) :
    (kind_q == oob_pkg::SIG_INIT_RESET) ? LEN_W'(`OOB_INIT_IDLE_UNITS) : LEN_W'(`OOB_IDENT_IDLE_UNITS);
  wire logic [LEN_W-1:0] neg_len = (kind_q == oob_pkg::SIG_WAKE) ? LEN_W'(`OOB_WAKE_NEG_UNITS) :
    (kind_q == oob_pkg::SIG_INIT_RESET) ? LEN_W'(`OOB_INIT_NEG_UNITS) : LEN_W'(`OOB_IDENT_NEG_UNITS);
  wire logic [LEN_W-1:0] cur_len = (state_q == oob_pkg::ST_BURST) ? LEN_W'(`OOB_BURST_UNITS) :
    (state_q == oob_pkg::ST_NEGATE) ? neg_len : idle_len;
  wire oob_pkg::link_rate_t rate_sel = (i_sata_supported || i_gen1_capable) ? oob_pkg::RATE_GEN1 :
    i_lowest_rate;
  wire logic [3:0] dwords_sel = (rate_sel == oob_pkg::RATE_GEN2) ? 4'(`OOB_GEN2_DWORDS_PER_BURST) :
    4'(`OOB_GEN1_DWORDS_PER_BURST);
  wire logic wait_expire = wait_q && (wait_cnt_q == CNT_W'(TIMEOUT_CYCLES - 1));
  wire logic ident_end = sig_end && (kind_q == oob_pkg::SIG_IDENTIFY);

  assign wait_d = ident_end ? 1'b1 : ((accept || i_identify_detected || wait_expire) ? 1'b0 : wait_q);

  // ----------------------------------------
  // Period timer
  // ----------------------------------------
  oob_interval_timer #(
    .LEN_W(LEN_W)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(accept),
    .i_run(state_q != oob_pkg::ST_IDLE),
    .i_len_units(cur_len),
    .o_done(timer_done)
  );

  // ----------------------------------------
  // Sequence control
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    rep_d = rep_q;
    case (state_q)
      oob_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = oob_pkg::ST_QUIET;
          rep_d = '0;
        end
      end
      oob_pkg::ST_QUIET: begin
        if (timer_done) begin
          state_d = oob_pkg::ST_BURST;
        end
      end
      oob_pkg::ST_BURST: begin
        if (timer_done) begin
          if (last_rep) begin
            state_d = oob_pkg::ST_NEGATE;
          end else begin
            state_d = oob_pkg::ST_QUIET;
            rep_d = rep_q + 3'h1;
          end
        end
      end
      oob_pkg::ST_NEGATE: begin
        if (timer_done) begin
          state_d = oob_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = oob_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= oob_pkg::ST_IDLE;
      rep_q <= '0;
    end else begin
      state_q <= state_d;
      rep_q <= rep_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      kind_q <= oob_pkg::SIG_WAKE;
      o_burst_rate <= oob_pkg::RATE_GEN1;
      o_burst_dwords <= 4'(`OOB_GEN1_DWORDS_PER_BURST);
    end else if (accept) begin
      kind_q <= i_req_kind;
      o_burst_rate <= rate_sel;
      o_burst_dwords <= dwords_sel;
    end
  end

  // ----------------------------------------
  // Line outputs and messages
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_tx_burst <= 1'b0;
      o_tx_dc_idle <= 1'b0;
      o_tx_ready <= 1'b1;
      o_wake_sent_msg <= 1'b0;
      o_init_sent_msg <= 1'b0;
      o_identify_sent_msg <= 1'b0;
    end else begin
      o_tx_burst <= state_d == oob_pkg::ST_BURST;
      o_tx_dc_idle <= (state_d == oob_pkg::ST_QUIET) || (state_d == oob_pkg::ST_NEGATE);
      o_tx_ready <= state_d == oob_pkg::ST_IDLE;
      o_wake_sent_msg <= sig_end && (kind_q == oob_pkg::SIG_WAKE);
      o_init_sent_msg <= sig_end && (kind_q == oob_pkg::SIG_INIT_RESET);
      o_identify_sent_msg <= ident_end;
    end
  end

  // ----------------------------------------
  // Identify reply wait
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wait_q <= 1'b0;
      wait_cnt_q <= '0;
      o_identify_timeout <= 1'b0;
    end else begin
      wait_q <= wait_d;
      wait_cnt_q <= wait_q ? wait_cnt_q + CNT_W'(1) : '0;
      o_identify_timeout <= wait_expire && !i_identify_detected && !accept;
    end
  end

  // ----------------------------------------
  // Assertion helpers
  // ----------------------------------------
  int run_q;
  int bursts_q;
  int since_ident_q;
  localparam int TO_LAST = TIMEOUT_CYCLES - 1;
  localparam int NEG_MAX = 330;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || state_d != state_q) begin
      run_q <= 0;
    end else begin
      run_q <= run_q + 1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || accept) begin
      bursts_q <= 0;
    end else if (o_tx_burst && !$past(o_tx_burst)) begin
      bursts_q <= bursts_q + 1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_identify_detected || accept) begin
      since_ident_q <= -1;
    end else if (o_identify_sent_msg) begin
      since_ident_q <= 1;
    end else if (since_ident_q > 0 && since_ident_q < 8191) begin
      since_ident_q <= since_ident_q + 1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_negate_done;
    state_q == oob_pkg::ST_NEGATE && timer_done;
  endsequence

  property p_period_len;
    (state_q != oob_pkg::ST_IDLE && timer_done) |->
      ((run_q + 1) * 15 + 14 >= 2 * int'(cur_len)) && ((run_q + 1) * 15 < 2 * int'(cur_len) + 15);
  endproperty
  a_period_len: assert property (p_period_len) else $error("Period length off");

  property p_burst_len;
    (state_q == oob_pkg::ST_BURST && timer_done) |-> (run_q == 20 || run_q == 21);
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("Burst not 160 units");

  property p_idle_len;
    (state_q == oob_pkg::ST_QUIET && timer_done) |->
      (kind_q == oob_pkg::SIG_WAKE) ? (run_q == 20 || run_q == 21) :
      (kind_q == oob_pkg::SIG_INIT_RESET) ? (run_q == 62 || run_q == 63) : (run_q == 190 || run_q == 191);
  endproperty
  a_idle_len: assert property (p_idle_len) else $error("Idle length wrong for signal");

  property p_neg_len;
    s_negate_done |->
      (kind_q == oob_pkg::SIG_WAKE) ? (run_q == 36 || run_q == 37) :
      (kind_q == oob_pkg::SIG_INIT_RESET) ? (run_q == 105 || run_q == 106) : (run_q == 318 || run_q == 319);
  endproperty
  a_neg_len: assert property (p_neg_len) else $error("Negation length wrong");

  property p_six_pairs;
    s_negate_done |=> (bursts_q == REPEATS) && !o_tx_burst;
  endproperty
  a_six_pairs: assert property (p_six_pairs) else $error("Wrong burst count");

  property p_line_exclusive;
    (o_tx_burst |-> !o_tx_dc_idle) and ((state_q != oob_pkg::ST_IDLE) |-> (o_tx_burst != o_tx_dc_idle));
  endproperty
  a_line_exclusive: assert property (p_line_exclusive) else $error("Burst and idle overlap");

  property p_burst_state;
    o_tx_burst == (state_q == oob_pkg::ST_BURST);
  endproperty
  a_burst_state: assert property (p_burst_state) else $error("Burst outside burst period");

  property p_sata_gen1;
    (accept && i_sata_supported) |=> o_burst_rate == oob_pkg::RATE_GEN1 && o_burst_dwords == 4'h4;
  endproperty
  a_sata_gen1: assert property (p_sata_gen1) else $error("SATA phy not at gen1");

  property p_not_faster;
    (accept && !i_sata_supported && !i_gen1_capable) |=>
      o_burst_rate == $past(i_lowest_rate) && o_burst_dwords == ((o_burst_rate == oob_pkg::RATE_GEN2) ? 4'h8 : 4'h4);
  endproperty
  a_not_faster: assert property (p_not_faster) else $error("Burst rate or count wrong");

  property p_msg;
    s_negate_done |=> o_tx_ready && $rose(o_tx_ready) &&
      (o_wake_sent_msg + o_init_sent_msg + o_identify_sent_msg == 1);
  endproperty
  a_msg: assert property (p_msg) else $error("Sent message missing");

  property p_msg_cause;
    (o_wake_sent_msg || o_init_sent_msg || o_identify_sent_msg) |-> $past(state_q) == oob_pkg::ST_NEGATE;
  endproperty
  a_msg_cause: assert property (p_msg_cause) else $error("Message without negation end");

  property p_timeout_min;
    o_identify_timeout |-> since_ident_q >= TIMEOUT_CYCLES - 1;
  endproperty
  a_timeout_min: assert property (p_timeout_min) else $error("Identify wait too short");

  property p_timeout_fires;
    (since_ident_q == TO_LAST && !i_identify_detected && !accept) |=> o_identify_timeout;
  endproperty
  a_timeout_fires: assert property (p_timeout_fires) else $error("Identify timeout late");

  property p_one_at_a_time;
    (state_q != oob_pkg::ST_IDLE) |=> $stable(kind_q) && !o_tx_ready ##0 1'b1 or
      ($past(state_q) == oob_pkg::ST_NEGATE);
  endproperty
  a_one_at_a_time: assert property (p_one_at_a_time) else $error("Request taken while busy");

  property p_neg_bound;
    (state_q == oob_pkg::ST_NEGATE) |-> run_q < NEG_MAX;
  endproperty
  a_neg_bound: assert property (p_neg_bound) else $error("Negation never ends");

endmodule : oob_signal_transmitter

// *** inc/oob_consts.svh ***
// Purpose: Timing and count constants of the OOB signal transmitter
// Assumes: 200 MHz core clock
// Notes: Times in thirds of a nanosecond; one OOB unit is two thirds
`ifndef OOB_CONSTS_SVH
`define OOB_CONSTS_SVH

// ----------------------------------------
// Clock and unit
// ----------------------------------------
`define OOB_CLK_PERIOD_PS 5000
`define OOB_UNIT_MIN_PS 666600
`define OOB_UNIT_MAX_PS 666733
`define OOB_UNIT_THIRDS_NS 2
`define OOB_CLK_THIRDS_NS ((`OOB_CLK_PERIOD_PS * 3) / 1000)

// ----------------------------------------
// Period lengths in OOB units
// ----------------------------------------
`define OOB_BURST_UNITS 160
`define OOB_WAKE_IDLE_UNITS 160
`define OOB_INIT_IDLE_UNITS 480
`define OOB_IDENT_IDLE_UNITS 1440
`define OOB_WAKE_NEG_UNITS 280
`define OOB_INIT_NEG_UNITS 800
`define OOB_IDENT_NEG_UNITS 2400
`define OOB_REPEATS 6

// ----------------------------------------
// Burst content and identify timeout
// ----------------------------------------
`define OOB_GEN1_DWORDS_PER_BURST 4
`define OOB_GEN2_DWORDS_PER_BURST 8
`define OOB_IDENT_TIMEOUT_NS 13650
`define OOB_IDENT_TIMEOUT_CYCLES ((`OOB_IDENT_TIMEOUT_NS * 1000 + `OOB_CLK_PERIOD_PS - 1) / `OOB_CLK_PERIOD_PS)

`endif

// *** inc/oob_pkg.sv ***
// Purpose: Types of the OOB signal transmitter
// Assumes: Nothing
// Notes: Init and host reset share one kind
package oob_pkg;

  // ----------------------------------------
  // Signal kinds, rates, states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SIG_WAKE,
    SIG_INIT_RESET,
    SIG_IDENTIFY
  } oob_sig_t;

  typedef enum logic {
    RATE_GEN1,
    RATE_GEN2
  } link_rate_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_QUIET,
    ST_BURST,
    ST_NEGATE
  } tx_state_t;

endpackage : oob_pkg

// *** design/oob_interval_timer.sv ***
// Purpose: Measures periods in OOB units on the core clock
// Assumes: Length stable while running
// Notes: Remainder carries into the next period when chained
`timescale 1ns/1ps
`include "oob_consts.svh"

module oob_interval_timer #(
  parameter int unsigned LEN_W = 12
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_load,
  input wire logic i_run,
  input wire logic [LEN_W-1:0] i_len_units,
  // Period end
  output logic o_done
);

  localparam int unsigned ACC_W = LEN_W + 2;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (LEN_W < 12 || LEN_W > 20) begin : g_bad_len_w
    $error("LEN_W out of range");
  end

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  wire logic [ACC_W-1:0] step = ACC_W'(`OOB_CLK_THIRDS_NS);
  wire logic [ACC_W-1:0] target = ACC_W'(i_len_units) * ACC_W'(`OOB_UNIT_THIRDS_NS);
  wire logic [ACC_W-1:0] acc_sum = acc_q + step;
  wire logic hit = acc_sum >= target;

  assign o_done = i_run && hit;
  assign acc_d = i_load ? '0 : (o_done ? acc_sum - target : (i_run ? acc_sum : acc_q));

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

endmodule : oob_interval_timer

// *** testbench/oob_line_receiver.sv ***
// Purpose: Far-side receiver model that measures OOB line runs
// Assumes: Burst and D.C. idle levels come from the transmitter
// Notes: Answers an identify signal after a set delay
`timescale 1ns/1ps

module oob_line_receiver (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Line levels
  input wire logic i_tx_burst,
  input wire logic i_tx_dc_idle,
  // Reply control
  input wire logic i_reply_en,
  input wire logic [7:0] i_reply_dly,
  // Measurements and reply
  output logic [3:0] o_pairs,
  output logic [9:0] o_idle_len,
  output logic [9:0] o_neg_len,
  output logic [9:0] o_burst_min,
  output logic [9:0] o_burst_max,
  output logic o_identify_detected
);
  logic [1:0] st_q;
  logic [9:0] cnt_q;
  logic [8:0] dly_q;
  // ----------------------------------------
  // Run measurement and reply
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q <= 2'h0;
      cnt_q <= 10'h000;
      o_pairs <= 4'h0;
      dly_q <= 9'h000;
      o_identify_detected <= 1'b0;
    end else begin
      st_q <= {i_tx_burst, i_tx_dc_idle};
      dly_q <= (dly_q != 9'h000) ? dly_q - 9'h001 : 9'h000;
      o_identify_detected <= (dly_q == 9'h001);
      if ({i_tx_burst, i_tx_dc_idle} == st_q) begin
        cnt_q <= cnt_q + 10'h001;
      end else begin
        cnt_q <= 10'h001;
        if (st_q == 2'h1 && i_tx_burst) o_idle_len <= cnt_q;
        if (st_q == 2'h1 && !i_tx_burst) o_neg_len <= cnt_q;
        // Long idle means identify; init and host reset look alike
        if (st_q == 2'h1 && !i_tx_burst && i_reply_en && o_idle_len > 10'h0A0) begin
          dly_q <= {1'b0, i_reply_dly} + 9'h002;
        end
        if (st_q == 2'h2) begin
          o_pairs <= o_pairs + 4'h1;
          o_burst_min <= (cnt_q < o_burst_min) ? cnt_q : o_burst_min;
          o_burst_max <= (cnt_q > o_burst_max) ? cnt_q : o_burst_max;
        end
        if (st_q == 2'h0) begin
          o_pairs <= 4'h0;
          o_burst_min <= 10'h3FF;
          o_burst_max <= 10'h000;
        end
      end
    end
  end
endmodule : oob_line_receiver

// *** testbench/oob_signal_transmitter_tb.sv ***
// Purpose: Self-checking bench of the OOB signal transmitter
// Assumes: Short identify wait of 20 cycles
// Notes: Driver queues notes, monitor checks each sent message
`timescale 1ns/1ps

module oob_signal_transmitter_tb;
  localparam int TMO = 20;
  typedef struct packed {
    logic [1:0] kind;
    logic rate;
    logic [3:0] dw;
    logic to;
  } note_t;
  note_t notes[$];
  note_t n;
  int t;
  int miscompares;
  int checked;
  int sent_cnt;
  int idle_lo[3] = '{21, 63, 191};
  int neg_lo[3] = '{37, 106, 319};
  logic clk, rst, req_valid, sata, g1, reply_en;
  oob_pkg::oob_sig_t req_kind;
  oob_pkg::link_rate_t low_rate, burst_rate;
  logic [7:0] reply_dly;
  logic tx_burst, tx_dc_idle, tx_ready, wake_msg, init_msg, id_msg, id_to, id_det;
  logic [3:0] burst_dwords, pairs;
  logic [9:0] idle_len, neg_len, bmin, bmax;

  // ----------------------------------------
  // Design and far side
  // ----------------------------------------
  oob_signal_transmitter #(.REPEATS(6), .TIMEOUT_CYCLES(TMO)) dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req_kind(req_kind),
    .i_sata_supported(sata), .i_gen1_capable(g1), .i_lowest_rate(low_rate),
    .i_identify_detected(id_det), .o_tx_burst(tx_burst), .o_tx_dc_idle(tx_dc_idle),
    .o_burst_rate(burst_rate), .o_burst_dwords(burst_dwords), .o_tx_ready(tx_ready),
    .o_wake_sent_msg(wake_msg), .o_init_sent_msg(init_msg),
    .o_identify_sent_msg(id_msg), .o_identify_timeout(id_to));
  oob_line_receiver rx_u (
    .i_core_clk(clk), .i_rst(rst), .i_tx_burst(tx_burst), .i_tx_dc_idle(tx_dc_idle),
    .i_reply_en(reply_en), .i_reply_dly(reply_dly), .o_pairs(pairs), .o_idle_len(idle_len),
    .o_neg_len(neg_len), .o_burst_min(bmin), .o_burst_max(bmax), .o_identify_detected(id_det));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  task automatic wait_ready;
    int k;
    k = 0;
    while (tx_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
      if (k > 4000) begin
        miscompares++;
        end_sim;
      end
    end
  endtask : wait_ready

  // Request held high while busy, so it is first refused, then taken
  task automatic send(input int k, input logic en, input logic [7:0] dly, input logic to);
    note_t m;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_kind = oob_pkg::oob_sig_t'(k);
    sata = 1'($urandom);
    g1 = 1'($urandom);
    low_rate = oob_pkg::link_rate_t'($urandom_range(1, 0));
    if (k == 1) begin
      sata = 1'b0;
      g1 = 1'b0;
      low_rate = oob_pkg::link_rate_t'(sent_cnt[0]);
    end
    sent_cnt++;
    reply_en = en;
    reply_dly = dly;
    m.kind = 2'(k);
    m.rate = (sata | g1) ? 1'b0 : low_rate;
    m.dw = m.rate ? 4'h8 : 4'h4;
    m.to = to;
    notes.push_back(m);
    wait_ready;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    sata = 1'($urandom);
    g1 = 1'($urandom);
  endtask : send

  // ----------------------------------------
  // Clock, watchdog, monitor
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #400000;
    miscompares++;
    end_sim;
  end

  initial forever begin
    @(posedge clk);
    #2;
    if ({id_msg, init_msg, wake_msg} !== 3'h0) begin
      check(10'(notes.size() > 0), 10'h001);
      n = notes.pop_front();
      check(10'({id_msg, init_msg, wake_msg}), 10'(1 << n.kind));
      check(10'(burst_rate), 10'(n.rate));
      check(10'(burst_dwords), 10'(n.dw));
      check(10'(tx_ready), 10'h001);
      @(posedge clk);
      #2;
      check(10'(pairs), 10'h006);
      check(10'(bmin >= 21 && bmax <= 22), 10'h001);
      check(10'(idle_len >= idle_lo[n.kind] && idle_len <= idle_lo[n.kind] + 1), 10'h001);
      check(10'(neg_len >= neg_lo[n.kind] && neg_len <= neg_lo[n.kind] + 1), 10'h001);
      if (n.kind == 2'h2) begin
        t = 0;
        for (int k = 2; k <= TMO + 6; k++) begin
          @(posedge clk);
          #2;
          if (id_to === 1'b1) t = k;
        end
        check(10'(t), n.to ? 10'(TMO) : 10'h000);
      end
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, req_valid, sata, g1, reply_en} = 5'h10;
    req_kind = oob_pkg::SIG_WAKE;
    low_rate = oob_pkg::RATE_GEN1;
    reply_dly = 8'h00;
    miscompares = 0;
    checked = 0;
    sent_cnt = 0;
    void'($urandom(32'h7455323D));
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    check(10'({tx_ready, tx_burst, tx_dc_idle, burst_rate}), 10'h008);
    check(10'(burst_dwords), 10'h004);
    $display("test reset done");
    for (int i = 0; i < 9; i++) send(i % 3, 1'b1, 8'h03, 1'b0);
    wait_ready;
    repeat (TMO + 8) @(posedge clk);
    $display("test all kinds back to back done");
    send(2, 1'b1, 8'h28, 1'b1);
    wait_ready;
    repeat (TMO + 50) @(posedge clk);
    send(2, 1'b0, 8'h00, 1'b1);
    wait_ready;
    repeat (TMO + 8) @(posedge clk);
    $display("test identify timeout done");
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    repeat (30) @(posedge clk);
    #1;
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    check(10'({tx_ready, tx_burst, tx_dc_idle}), 10'h004);
    send(1, 1'b0, 8'h00, 1'b0);
    wait_ready;
    repeat (TMO + 8) @(posedge clk);
    check(10'(notes.size()), 10'h000);
    $display("test reset mid signal done");
    end_sim;
  end
endmodule : oob_signal_transmitter_tb
